/* File: prc_pkg.sv */
// shared constants and types for the pressure readout host sequencer
package prc_pkg;

    // clock and timing
    localparam int CLK_HZ             = 32'h05f5_e100;
    localparam int TEMP_REFRESH_MS    = 32'h64;
    localparam int REFRESH_CYCLES     = CLK_HZ / 32'h3e8 * TEMP_REFRESH_MS;
    localparam int SAMPLE_RATE_SPS    = 32'h14;
    // least wait, so round up to whole cycles
    localparam int SAMPLE_WAIT_CYCLES = (CLK_HZ + SAMPLE_RATE_SPS - 32'h1) / SAMPLE_RATE_SPS;
    localparam int SCLK_HALF_NS       = 32'h28;
    // scaled through MHz so the product stays inside 32 bits
    localparam int SCLK_HALF_CYCLES   = SCLK_HALF_NS * (CLK_HZ / 32'h000f_4240) / 32'h3e8;

    // calibration memory byte map
    localparam int EE_RANGE_ADDR  = 32'h1b;
    localparam int EE_PMIN_ADDR   = 32'h1f;
    localparam int EE_CFG0_ADDR   = 32'h3d;
    localparam int EE_CFG_STEP    = 32'h2;
    localparam int EE_OFFSET_ADDR = 32'h82;
    localparam int EE_GAIN_ADDR   = 32'hd2;
    localparam int EE_LIN_ADDR    = 32'h122;
    localparam int COEF_STEP      = 32'h4;
    localparam logic [7:0] EE_CMD_READ = 8'h03;
    localparam logic [7:0] EE_ADDR_LO  = 8'h00;
    localparam logic [8:0] EE_HDR_LEN  = 9'h002;
    // covers the last linearity coefficient, bytes up to 305
    localparam logic [8:0] EE_READ_LEN = 9'h132;
    localparam logic [8:0] EE_TXN_LEN  = EE_HDR_LEN + EE_READ_LEN;

    // converter commands and fields
    localparam logic [7:0] ADC_CMD_RESET = 8'h06;
    localparam logic [7:0] ADC_CMD_WREG4 = 8'h43;
    localparam logic [7:0] ADC_CMD_WREG1 = 8'h44;
    localparam logic [7:0] ADC_CMD_START = 8'h08;
    localparam logic [7:0] ADC_CMD_RDATA = 8'h10;
    localparam int         ADC_RATE_LSB  = 32'h5;
    localparam int         ADC_RATE_W    = 32'h3;
    localparam int         ADC_TS_BIT    = 32'h1;
    localparam logic [8:0] ACFG_LEN      = 9'h005;
    localparam logic [8:0] CONV_LEN      = 9'h003;
    localparam logic [8:0] READ_LEN      = 9'h004;
    localparam logic [8:0] SINGLE_LEN    = 9'h001;
    localparam int         RAW_W         = 32'h18;

    typedef enum logic [15:0] {
        S_IDLE  = 16'h0001, S_EE    = 16'h0002, S_ARST  = 16'h0004, S_ACFG  = 16'h0008,
        S_TCONV = 16'h0010, S_TWAIT = 16'h0020, S_TREAD = 16'h0040, S_DELAY = 16'h0080,
        S_PCONV = 16'h0100, S_PWAIT = 16'h0200, S_PREAD = 16'h0400, S_OFF   = 16'h0800,
        S_SPAN  = 16'h1000, S_DIV   = 16'h2000, S_SHAPE = 16'h4000, S_ENG   = 16'h8000
    } prc_state_e;

endpackage

/* File: prc_readout.sv */
// host sequencer and compensation datapath for a raw-output pressure sensor
//
// Function
// - converter_select_n low only while addressing the converter, high otherwise.
// - memory_select_n low only while reading calibration memory, high otherwise.
// - read converter settings and all coefficients from memory before any conversion.
// - program the converter with the fetched settings before any measurement.
// - optionally replace the converter sample rate after initialisation.
// - after storing temperature, wait one sample period before pressure conversion.
// - basic mode repeats temperature, wait, pressure continuously.
// - fast mode repeats pressure conversions, fresh temperature after loop count.
// - refresh temperature about every 100 ms.
// - offset_corrected is raw pressure minus offset cubic in raw temperature.
// - span_corrected is offset_corrected divided by gain cubic in raw temperature.
// - fullscale_result is linearity cubic of span_corrected.
// - engineering result is fullscale_result times range plus minimum.
// - coefficients and raw readings converted to a common numeric format first.
`timescale 1ns/1ps
module prc_readout #(
    parameter int DW          = 64,
    parameter int FRAC        = 32,
    parameter int LOOP_W      = 8,
    parameter int SAMPLE_WAIT = prc_pkg::SAMPLE_WAIT_CYCLES,
    parameter int REFRESH     = prc_pkg::REFRESH_CYCLES
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          run,
    input  wire logic                          fast_mode,
    input  wire logic [LOOP_W-1:0]             loop_count,
    input  wire logic                          rate_update_en,
    input  wire logic [prc_pkg::ADC_RATE_W-1:0] rate_code,
    input  wire logic                          result_available_n,
    input  wire logic                          serial_from_dev,
    output logic                               sclk,
    output logic                               serial_to_dev,
    output logic                               converter_select_n,
    output logic                               memory_select_n,
    output logic signed [DW-1:0]               pressure_out,
    output logic [prc_pkg::RAW_W-1:0]          temp_raw_out,
    output logic [prc_pkg::RAW_W-1:0]          pressure_raw_out,
    output logic                               result_valid,
    output logic                               init_done
);
    localparam int DIVN = DW + FRAC;
    localparam int HALF = (prc_pkg::SCLK_HALF_CYCLES < 1) ? 1 : prc_pkg::SCLK_HALF_CYCLES;

    prc_pkg::prc_state_e state_r, state_nxt;
    logic [7:0]          ee_mem [0:prc_pkg::EE_READ_LEN-1];
    logic [7:0]          half_r, half_nxt;
    logic                sclk_r, sclk_nxt, mosi_r, mosi_nxt;
    logic [2:0]          bit_r, bit_nxt;
    logic [8:0]          byte_r, byte_nxt;
    logic [7:0]          rx_r, rx_nxt, tx_cur, cfg1_eff;
    logic                csa_n_r, csa_n_nxt, cse_n_r, cse_n_nxt;
    logic                rdy_s1_r, rdy_s2_r, din_s1_r, din_s2_r;
    logic [23:0]         raw_r, raw_nxt, traw_r, traw_nxt, praw_r, praw_nxt;
    logic [31:0]         dly_r, dly_nxt, ref_r, ref_nxt;
    logic [LOOP_W-1:0]   loops_r, loops_nxt;
    logic signed [DW-1:0] acc_r, acc_nxt, off_r, off_nxt, span_r, span_nxt, fs_r, fs_nxt;
    logic signed [DW-1:0] pres_r, pres_nxt, tfix, pfix, hx, horner;
    logic [DW-1:0]       den_r, den_nxt;
    logic [1:0]          hidx_r, hidx_nxt;
    logic [DIVN-1:0]     dvd_r, dvd_nxt;
    logic [DW:0]         rem_r, rem_nxt, rem_t;
    logic [7:0]          dcnt_r, dcnt_nxt;
    logic                qneg_r, qneg_nxt, valid_r, valid_nxt, init_r, init_nxt;
    logic                tick, byte_end, txn_done, ee_wr;
    int                  hbase;

    function automatic logic is_adc(input prc_pkg::prc_state_e s);
        return s inside {prc_pkg::S_ARST, prc_pkg::S_ACFG, prc_pkg::S_TCONV,
                         prc_pkg::S_TREAD, prc_pkg::S_PCONV, prc_pkg::S_PREAD};
    endfunction

    function automatic logic [8:0] txn_len(input prc_pkg::prc_state_e s);
        case (s)
            prc_pkg::S_EE:                   return prc_pkg::EE_TXN_LEN;
            prc_pkg::S_ACFG:                 return prc_pkg::ACFG_LEN;
            prc_pkg::S_TCONV, prc_pkg::S_PCONV: return prc_pkg::CONV_LEN;
            prc_pkg::S_TREAD, prc_pkg::S_PREAD: return prc_pkg::READ_LEN;
            default:                         return prc_pkg::SINGLE_LEN;
        endcase
    endfunction

    // stored single-precision word to signed fixed point; magnitude overflow wraps
    function automatic logic signed [DW-1:0] f2fix(input logic [31:0] f);
        logic [DW-1:0] m;
        logic [DW-1:0] r;
        int            sh;
        m  = {{(DW-24){1'b0}}, 1'b1, f[22:0]};
        sh = int'(f[30:23]) - 32'h96 + FRAC;
        if (f[30:23] == 8'h00) r = '0;
        else if (sh >= 0)      r = m << sh;
        else                   r = m >> (-sh);
        return f[31] ? -$signed(r) : $signed(r);
    endfunction

    function automatic logic signed [DW-1:0] coef(input int addr);
        return f2fix({ee_mem[addr+3], ee_mem[addr+2], ee_mem[addr+1], ee_mem[addr]});
    endfunction

    function automatic logic signed [DW-1:0] mulfix(input logic signed [DW-1:0] a,
                                                    input logic signed [DW-1:0] b);
        logic signed [2*DW-1:0] p;
        p = a * b;
        return p[FRAC +: DW];
    endfunction

    function automatic logic [DW-1:0] absv(input logic signed [DW-1:0] x);
        return x[DW-1] ? DW'(-x) : DW'(x);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    assign sclk               = sclk_r;
    assign serial_to_dev      = mosi_r;
    assign converter_select_n = csa_n_r;
    assign memory_select_n    = cse_n_r;
    assign pressure_out       = pres_r;
    assign temp_raw_out       = traw_r;
    assign pressure_raw_out   = praw_r;
    assign result_valid       = valid_r;
    assign init_done          = init_r;

    // raw readings carry no correction, so they enter the datapath as plain integers
    assign tfix = $signed({{(DW-24-FRAC){traw_r[23]}}, traw_r, {FRAC{1'b0}}});
    assign pfix = $signed({{(DW-24-FRAC){praw_r[23]}}, praw_r, {FRAC{1'b0}}});

    ////////////////////////////////////////////////////////////////////////////////
    // pins from the sensor side pass two flops before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdy_s1_r <= 1'b1;
            rdy_s2_r <= 1'b1;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            rdy_s1_r <= result_available_n;
            rdy_s2_r <= rdy_s1_r;
            din_s1_r <= serial_from_dev;
            din_s2_r <= din_s1_r;
        end
    end

    always_ff @(posedge clk) begin
        if (ee_wr) ee_mem[byte_r - prc_pkg::EE_HDR_LEN] <= rx_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        {state_nxt, half_nxt, sclk_nxt, bit_nxt, byte_nxt, rx_nxt} =
            {state_r, half_r, sclk_r, bit_r, byte_r, rx_r};
        {raw_nxt, traw_nxt, praw_nxt, dly_nxt, loops_nxt} = {raw_r, traw_r, praw_r, dly_r, loops_r};
        {acc_nxt, off_nxt, span_nxt, fs_nxt, pres_nxt, den_nxt} = {acc_r, off_r, span_r, fs_r, pres_r, den_r};
        {hidx_nxt, dvd_nxt, rem_nxt, dcnt_nxt, qneg_nxt, init_nxt} =
            {hidx_r, dvd_r, rem_r, dcnt_r, qneg_r, init_r};
        valid_nxt = 1'b0;
        tick      = 1'b0;
        rem_t     = {rem_r[DW-1:0], dvd_r[DIVN-1]};
        // rate override only touches the rate field of register 1
        cfg1_eff  = ee_mem[prc_pkg::EE_CFG0_ADDR + prc_pkg::EE_CFG_STEP];
        if (rate_update_en) cfg1_eff[prc_pkg::ADC_RATE_LSB +: prc_pkg::ADC_RATE_W] = rate_code;
        case (state_r)
            prc_pkg::S_EE:    tx_cur = (byte_r == 9'h000) ? prc_pkg::EE_CMD_READ : prc_pkg::EE_ADDR_LO;
            prc_pkg::S_ARST:  tx_cur = prc_pkg::ADC_CMD_RESET;
            prc_pkg::S_ACFG:  tx_cur = (byte_r == 9'h000) ? prc_pkg::ADC_CMD_WREG4 :
                                       (byte_r == 9'h002) ? cfg1_eff :
                                       ee_mem[prc_pkg::EE_CFG0_ADDR + prc_pkg::EE_CFG_STEP * (int'(byte_r) - 1)];
            prc_pkg::S_TCONV, prc_pkg::S_PCONV: begin
                tx_cur = cfg1_eff;
                tx_cur[prc_pkg::ADC_TS_BIT] = (state_r == prc_pkg::S_TCONV);
                if (byte_r == 9'h000) tx_cur = prc_pkg::ADC_CMD_WREG1;
                if (byte_r == 9'h002) tx_cur = prc_pkg::ADC_CMD_START;
            end
            prc_pkg::S_TREAD, prc_pkg::S_PREAD:
                              tx_cur = (byte_r == 9'h000) ? prc_pkg::ADC_CMD_RDATA : 8'h00;
            default:          tx_cur = 8'h00;
        endcase
        mosi_nxt = tx_cur[3'h7 - bit_r];

        // serial engine: sample on the rising edge, shift on the falling edge
        if (is_adc(state_r) || state_r == prc_pkg::S_EE) begin
            if (half_r == 8'(HALF - 1)) begin
                half_nxt = 8'h00;
                tick     = 1'b1;
            end else begin
                half_nxt = half_r + 8'h01;
            end
        end else begin
            half_nxt = 8'h00;
        end
        byte_end = tick && sclk_r && (bit_r == 3'h7);
        txn_done = byte_end && (byte_r == txn_len(state_r) - 9'h001);
        ee_wr    = byte_end && (state_r == prc_pkg::S_EE) && (byte_r >= prc_pkg::EE_HDR_LEN);
        if (tick) begin
            sclk_nxt = ~sclk_r;
            if (!sclk_r) rx_nxt = {rx_r[6:0], din_s2_r};
            else if (bit_r == 3'h7) begin
                bit_nxt  = 3'h0;
                byte_nxt = byte_r + 9'h001;
            end else begin
                bit_nxt = bit_r + 3'h1;
            end
        end
        if (byte_end && (state_r == prc_pkg::S_TREAD || state_r == prc_pkg::S_PREAD))
            raw_nxt = {raw_r[15:0], rx_r};
        if (txn_done) byte_nxt = 9'h000;

        // shared cubic evaluator, Horner form
        hx     = (state_r == prc_pkg::S_SHAPE) ? span_r : tfix;
        hbase  = (state_r == prc_pkg::S_OFF)  ? prc_pkg::EE_OFFSET_ADDR :
                 (state_r == prc_pkg::S_SPAN) ? prc_pkg::EE_GAIN_ADDR : prc_pkg::EE_LIN_ADDR;
        horner = mulfix(acc_r, hx) + coef(hbase + prc_pkg::COEF_STEP * int'(hidx_r));
        if (state_r inside {prc_pkg::S_OFF, prc_pkg::S_SPAN, prc_pkg::S_SHAPE}) begin
            acc_nxt  = horner;
            hidx_nxt = hidx_r - 2'h1;
        end

        case (state_r)
            prc_pkg::S_IDLE: begin
                init_nxt = 1'b0;
                if (run) state_nxt = prc_pkg::S_EE;
            end
            prc_pkg::S_EE:    if (txn_done) state_nxt = prc_pkg::S_ARST;
            prc_pkg::S_ARST:  if (txn_done) state_nxt = prc_pkg::S_ACFG;
            prc_pkg::S_ACFG: if (txn_done) begin
                init_nxt  = 1'b1;
                state_nxt = prc_pkg::S_TCONV;
            end
            prc_pkg::S_TCONV: if (txn_done) state_nxt = prc_pkg::S_TWAIT;
            prc_pkg::S_TWAIT: if (!rdy_s2_r) state_nxt = prc_pkg::S_TREAD;
            prc_pkg::S_TREAD: if (txn_done) begin
                traw_nxt  = {raw_r[15:0], rx_r};
                state_nxt = prc_pkg::S_DELAY;
            end
            prc_pkg::S_DELAY: begin
                dly_nxt = dly_r + 32'h1;
                if (dly_r == 32'(SAMPLE_WAIT - 1)) begin
                    dly_nxt   = 32'h0;
                    state_nxt = prc_pkg::S_PCONV;
                end
            end
            prc_pkg::S_PCONV: if (txn_done) state_nxt = prc_pkg::S_PWAIT;
            prc_pkg::S_PWAIT: if (!rdy_s2_r) state_nxt = prc_pkg::S_PREAD;
            prc_pkg::S_PREAD: if (txn_done) begin
                praw_nxt  = {raw_r[15:0], rx_r};
                acc_nxt   = coef(prc_pkg::EE_OFFSET_ADDR + prc_pkg::COEF_STEP * 3);
                hidx_nxt  = 2'h2;
                state_nxt = prc_pkg::S_OFF;
            end
            prc_pkg::S_OFF: if (hidx_r == 2'h0) begin
                off_nxt   = pfix - horner;
                acc_nxt   = coef(prc_pkg::EE_GAIN_ADDR + prc_pkg::COEF_STEP * 3);
                hidx_nxt  = 2'h2;
                state_nxt = prc_pkg::S_SPAN;
            end
            prc_pkg::S_SPAN: if (hidx_r == 2'h0) begin
                den_nxt   = absv(horner);
                qneg_nxt  = off_r[DW-1] ^ horner[DW-1];
                dvd_nxt   = {absv(off_r), {FRAC{1'b0}}};
                rem_nxt   = '0;
                dcnt_nxt  = 8'h00;
                state_nxt = prc_pkg::S_DIV;
            end
            prc_pkg::S_DIV: begin
                // restoring divide, one quotient bit per cycle; a zero divisor sets every quotient bit, so span reads -1 (+1 when signs differ)
                if (rem_t >= {1'b0, den_r}) begin
                    rem_nxt = rem_t - {1'b0, den_r};
                    dvd_nxt = {dvd_r[DIVN-2:0], 1'b1};
                end else begin
                    rem_nxt = rem_t;
                    dvd_nxt = {dvd_r[DIVN-2:0], 1'b0};
                end
                dcnt_nxt = dcnt_r + 8'h01;
                if (dcnt_r == 8'(DIVN - 1)) begin
                    span_nxt  = qneg_r ? -$signed(dvd_nxt[DW-1:0]) : $signed(dvd_nxt[DW-1:0]);
                    acc_nxt   = coef(prc_pkg::EE_LIN_ADDR + prc_pkg::COEF_STEP * 3);
                    hidx_nxt  = 2'h2;
                    state_nxt = prc_pkg::S_SHAPE;
                end
            end
            prc_pkg::S_SHAPE: if (hidx_r == 2'h0) begin
                fs_nxt    = horner;
                state_nxt = prc_pkg::S_ENG;
            end
            prc_pkg::S_ENG: begin
                pres_nxt  = mulfix(fs_r, coef(prc_pkg::EE_RANGE_ADDR)) + coef(prc_pkg::EE_PMIN_ADDR);
                valid_nxt = 1'b1;
                if (!run) begin
                    state_nxt = prc_pkg::S_IDLE;
                end else if (fast_mode && (loops_r + LOOP_W'(1) < loop_count) && (ref_r < 32'(REFRESH))) begin
                    loops_nxt = loops_r + LOOP_W'(1);
                    state_nxt = prc_pkg::S_PCONV;
                end else begin
                    loops_nxt = '0;
                    state_nxt = prc_pkg::S_TCONV;
                end
            end
            default: state_nxt = prc_pkg::S_IDLE;
        endcase
        // refresh age counts from each temperature command
        ref_nxt   = (state_nxt == prc_pkg::S_TCONV && state_r != prc_pkg::S_TCONV) ? 32'h0 :
                    (ref_r == 32'hffff_ffff) ? ref_r : ref_r + 32'h1;
        cse_n_nxt = !(state_nxt == prc_pkg::S_EE);
        csa_n_nxt = !is_adc(state_nxt);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= prc_pkg::S_IDLE;
            {half_r, sclk_r, mosi_r, bit_r, byte_r, rx_r} <= '0;
            {csa_n_r, cse_n_r} <= 2'h3;
            {raw_r, traw_r, praw_r, dly_r, ref_r, loops_r} <= '0;
            {acc_r, off_r, span_r, fs_r, pres_r, den_r} <= '0;
            {hidx_r, dvd_r, rem_r, dcnt_r, qneg_r, valid_r, init_r} <= '0;
        end else begin
            state_r <= state_nxt;
            {half_r, sclk_r, mosi_r, bit_r, byte_r, rx_r} <= {half_nxt, sclk_nxt, mosi_nxt, bit_nxt, byte_nxt, rx_nxt};
            {csa_n_r, cse_n_r} <= {csa_n_nxt, cse_n_nxt};
            {raw_r, traw_r, praw_r, dly_r, ref_r, loops_r} <= {raw_nxt, traw_nxt, praw_nxt, dly_nxt, ref_nxt, loops_nxt};
            {acc_r, off_r, span_r, fs_r, pres_r, den_r} <= {acc_nxt, off_nxt, span_nxt, fs_nxt, pres_nxt, den_nxt};
            {hidx_r, dvd_r, rem_r, dcnt_r, qneg_r, valid_r, init_r} <=
                {hidx_nxt, dvd_nxt, rem_nxt, dcnt_nxt, qneg_nxt, valid_nxt, init_nxt};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_temp_stored;
        state_r == prc_pkg::S_TREAD && txn_done;
    endsequence
    sequence s_hold_delay;
        (state_r == prc_pkg::S_DELAY && converter_select_n)[*8];
    endsequence

    a_sel_exclusive: assert property (converter_select_n || memory_select_n)
        else $error("both selects low");
    a_mem_sel_scope: assert property (!memory_select_n |-> state_r == prc_pkg::S_EE)
        else $error("memory select low outside memory read");
    a_adc_sel_scope: assert property (!converter_select_n |-> is_adc(state_r) && init_r == (state_r != prc_pkg::S_ARST && state_r != prc_pkg::S_ACFG))
        else $error("converter select low outside converter access");
    a_ee_first_step: assert property ($rose(state_r == prc_pkg::S_ARST) |-> $past(state_r) == prc_pkg::S_EE)
        else $error("converter reset not preceded by memory fetch");
    a_cfg_before_conv: assert property ($rose(state_r == prc_pkg::S_TCONV) |-> init_r && ($past(state_r) == prc_pkg::S_ACFG || $past(state_r) == prc_pkg::S_ENG))
        else $error("conversion before converter setup");
    a_temp_wait: assert property (s_temp_stored |=> s_hold_delay)
        else $error("pressure started too soon after temperature");
    a_delay_length: assert property ($rose(state_r == prc_pkg::S_PCONV) && $past(state_r) == prc_pkg::S_DELAY |-> $past(dly_r) == 32'(SAMPLE_WAIT - 1))
        else $error("sample period wait has wrong length");
    a_basic_repeat: assert property (state_r == prc_pkg::S_ENG && run && !fast_mode |=> state_r == prc_pkg::S_TCONV ##1 !converter_select_n)
        else $error("basic mode skipped temperature");
    a_fast_refresh: assert property ($rose(state_r == prc_pkg::S_PCONV) && $past(state_r) == prc_pkg::S_ENG |-> $past(fast_mode) && $past(ref_r) < 32'(REFRESH))
        else $error("pressure reuse outside fast mode or stale temperature");
    a_read_on_ready: assert property ($rose(state_r == prc_pkg::S_TREAD) || $rose(state_r == prc_pkg::S_PREAD) |-> $past(rdy_s2_r) == 1'b0)
        else $error("result read before ready");
    a_result_pulse: assert property (result_valid |-> $past(state_r) == prc_pkg::S_ENG ##1 !result_valid)
        else $error("result strobe malformed");
endmodule

/* File: prc_sensor_model.sv */
// behavioural sensor: calibration memory plus raw converter
`timescale 1ns/1ps
module prc_sensor_model (
    input  wire logic clk,
    input  wire logic sclk,
    input  wire logic serial_to_dev,
    input  wire logic converter_select_n,
    input  wire logic memory_select_n,
    output logic      result_available_n,
    output logic      serial_from_dev
);
    logic        sclk_d = 1'b0, csel_d = 1'b1, rd = 1'b0, tsel = 1'b0;
    logic [7:0]  sh = 8'h00, prev = 8'h00, mb, cfg_seen = 8'h00;
    logic [23:0] raw;
    int          bits = 0, dly = -1, temp_convs = 0;
    initial begin
        result_available_n = 1'b1;
        serial_from_dev    = 1'b0;
    end
    always @(posedge clk) begin
        raw = tsel ? 24'h123456 : 24'h654321;
        mb  = (bits / 8 == 36) ? 8'h40 : 8'h00;
        if (memory_select_n && converter_select_n) begin
            bits = 0;
            // released line must not look like a held bit
            serial_from_dev <= ~serial_from_dev;
        end else if (sclk && !sclk_d) begin
            sh = {sh[6:0], serial_to_dev};
            bits++;
            if (bits % 8 == 0) begin
                if (bits == 8) rd = (sh == 8'h10);
                if (prev == 8'h44) begin
                    tsel     = sh[1];
                    cfg_seen = sh;
                end
                if (prev == 8'h44 && sh[1]) temp_convs++;
                prev = sh;
            end
        end else if (!sclk && sclk_d) begin
            serial_from_dev <= !memory_select_n ? mb[7 - bits % 8] :
                               (rd && bits >= 8 && bits < 32) ? raw[31 - bits] : 1'b0;
        end
        if (!converter_select_n) result_available_n <= 1'b1;
        else if (!csel_d && !rd) dly = 20;
        if (dly == 0) result_available_n <= 1'b0;
        if (dly >= 0) dly--;
        sclk_d = sclk;
        csel_d = converter_select_n;
    end
endmodule

/* File: tb_prc_readout.sv */
// self-checking bench for the pressure readout sequencer
`timescale 1ns/1ps
module tb_prc_readout;
    localparam int SW = 50;
    logic               clk = 1'b0, rst = 1'b1, run = 1'b0, fast_mode = 1'b0;
    logic [7:0]         loop_count = 8'h00;
    logic               rate_en = 1'b0;
    logic [2:0]         rate_code = 3'h0;
    logic               sclk, mosi, csel_n, msel_n, rdy_n, miso, result_valid, init_done;
    logic signed [63:0] pressure_out;
    logic [23:0]        temp_raw_out, pressure_raw_out;
    int                 mismatches = 0, checked = 0, n, c, t0;
    prc_readout #(.SAMPLE_WAIT(SW), .REFRESH(20000)) dut_u (.clk(clk), .rst(rst), .run(run),
        .fast_mode(fast_mode), .loop_count(loop_count), .rate_update_en(rate_en), .rate_code(rate_code),
        .result_available_n(rdy_n), .serial_from_dev(miso), .sclk(sclk), .serial_to_dev(mosi),
        .converter_select_n(csel_n), .memory_select_n(msel_n), .pressure_out(pressure_out),
        .temp_raw_out(temp_raw_out), .pressure_raw_out(pressure_raw_out),
        .result_valid(result_valid), .init_done(init_done));
    prc_sensor_model model_u (.clk(clk), .sclk(sclk), .serial_to_dev(mosi), .converter_select_n(csel_n),
        .memory_select_n(msel_n), .result_available_n(rdy_n), .serial_from_dev(miso));
    task automatic compare(input string name, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        compare("wait bound", 64'h1, 64'(n < lim));
    endtask
    task automatic t_init();
        run <= 1'b1;
        wait_for(msel_n, 1'b0, 10);
        compare("converter idle", 64'h1, 64'(csel_n));
        wait_for(msel_n, 1'b1, 20000);
        compare("memory frame", 64'(16 * prc_pkg::SCLK_HALF_CYCLES * prc_pkg::EE_TXN_LEN), 64'(n));
        wait_for(csel_n, 1'b0, 20);
        wait_for(init_done, 1'b1, 2000);
    endtask
    task automatic t_basic();
        wait_for(model_u.rd, 1'b1, 3000);
        wait_for(csel_n, 1'b1, 1000);
        wait_for(csel_n, 1'b0, SW + 100);
        compare("sample wait", 64'h1, 64'(n >= SW));
        wait_for(result_valid, 1'b1, 3000);
        compare("temp raw", 64'h123456, 64'(temp_raw_out));
        compare("pressure raw", 64'h654321, 64'(pressure_raw_out));
        compare("pressure", 64'h0000_0002_0000_0000, pressure_out);
        @(posedge clk);
        wait_for(result_valid, 1'b1, 3000);
        compare("temp count", 64'h2, 64'(model_u.temp_convs));
    endtask
    task automatic t_fast();
        fast_mode  <= 1'b1;
        loop_count <= 8'h03;
        t0 = model_u.temp_convs;
        for (n = 0; n < 5000 && model_u.temp_convs == t0; n++) @(posedge clk);
        t0 = model_u.temp_convs;
        c  = 0;
        for (n = 0; n < 20000 && model_u.temp_convs == t0; n++) begin
            @(posedge clk);
            if (result_valid === 1'b1) c++;
        end
        compare("fast loops", 64'h3, 64'(c));
    endtask
    task automatic t_rate();
        rate_en   <= 1'b1;
        rate_code <= 3'h5;
        wait_for(result_valid, 1'b1, 3000);
        compare("rate field", 64'h5, 64'(model_u.cfg_seen[7:5]));
        compare("pressure select", 64'h0, 64'(model_u.cfg_seen[1]));
        run <= 1'b0;
        wait_for(init_done, 1'b0, 3000);
        compare("selects idle", 64'h3, 64'({csel_n, msel_n}));
    endtask
    always @(posedge clk) if (!rst && !msel_n && !csel_n) compare("one select", 64'h0, 64'h1);
    initial forever #5 clk = ~clk;
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_init();
        t_basic();
        t_fast();
        t_rate();
        tally_and_finish();
    end
endmodule
